// ---- hdl/accel_sample_fifo.v ----
// Three-axis acceleration sample buffer with its registers and pin routing
`timescale 1ns/1ps
`default_nettype none
`include "accel_fifo_consts.vh"

// Summary of operation
// - Three-bit mode field picks bypass, fill, stream or three triggered modes.
// - Empty flag reads one whenever no triplet is stored.
// - On a new sample with count at or above watermark, watermark flag sets.
// - On a triplet read with count at or below watermark, watermark flag clears.
// - Overwriting a stored slot sets the overrun flag.
// - Buffer works only while the enable bit in control_three is one.
// - Bypass keeps the buffer empty; writing bypass resets its contents.
// - Fill mode stores triplets into successive slots until full.
// - Fill mode stops taking samples after the first overwrite and overrun.
// - Thirty-two slots, each holding one X, one Y and one Z sample.
// - Stop-at-watermark limits depth to watermark level minus one, or one slot for levels zero and one.
// - Stream mode drops the oldest triplet to make room for a new one.
// - Stream drained before overrun repeats last triplet first in next burst.
// - Watermark, empty and overrun each routable to either interrupt pin.
// - Stream-to-fill runs stream while active flag is zero, fill when one.
// - Bypass-to-stream runs stream while active flag is one, else bypass.
// - Bypass-to-fill holds reset while flag is zero, fill while one.
// - Bypass-to-fill collects until the first triplet is overwritten, then stops.
// - Reading the X low byte pops the oldest triplet into the output registers.
// - Burst reads wrap from the Z high byte back to the X low byte.
module accel_sample_fifo #(
    parameter SLOTS = 32,
    parameter AW    = 5,
    parameter SW    = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire [6:0]    regAddr,
    input  wire          regWr,
    input  wire [7:0]    regWrData,
    input  wire          regRd,
    input  wire          regRdNext,
    output reg  [7:0]    regRdData,
    input  wire          sampleValid,
    input  wire [SW-1:0] sampleX,
    input  wire [SW-1:0] sampleY,
    input  wire [SW-1:0] sampleZ,
    input  wire          eventGenActive,
    output wire [7:0]    eventGenConfig,
    output wire [7:0]    eventGenXLevel,
    output wire [7:0]    eventGenYLevel,
    output wire [7:0]    eventGenZLevel,
    output wire          eventGenLatchRequest,
    output wire          interruptPinOne,
    output wire          interruptPinTwo
);

    // Effective behaviour of the buffer
    localparam [1:0] BEH_BYPASS = 2'b00;
    localparam [1:0] BEH_FILL   = 2'b01;
    localparam [1:0] BEH_STREAM = 2'b10;

    localparam [AW:0] FULL_DEPTH = SLOTS;
    localparam [AW:0] ONE_SLOT   = 1;
    localparam [AW:0] ZERO_COUNT = 0;
    localparam [AW:0] MAX_FIELD  = (1 << AW) - 1;
    localparam [AW-1:0] PTR_ZERO = 0;
    localparam [AW-1:0] PTR_ONE  = 1;
    // Maps mode code and active flag onto a plain behaviour
    function [1:0] behaviour;
        input       enable;
        input [2:0] code;
        input       active;
        begin
            behaviour = BEH_BYPASS;
            if (enable) begin
                case (code)
                    `MODE_FILL:             behaviour = BEH_FILL;
                    `MODE_STREAM:           behaviour = BEH_STREAM;
                    `MODE_STREAM_TO_FILL:
                        behaviour = active ? BEH_FILL : BEH_STREAM;
                    `MODE_BYPASS_TO_STREAM:
                        behaviour = active ? BEH_STREAM : BEH_BYPASS;
                    `MODE_BYPASS_TO_FILL:
                        behaviour = active ? BEH_FILL : BEH_BYPASS;
                    default:                behaviour = BEH_BYPASS;
                endcase
            end
        end
    endfunction

    // Address that follows a read, wrapping inside the output window
    function [6:0] nextAddr;
        input [6:0] addr;
        begin
            if (addr == `ADDR_Z_HIGH) begin
                nextAddr = `ADDR_X_LOW;
            end else begin
                nextAddr = addr + 7'h01;
            end
        end
    endfunction

    // Software registers
    reg  [7:0]    ctrlThree_q, ctrlSix_q, ctrlSeven_q, bufCtrl_q;
    reg  [7:0]    egConfig_q, egXLevel_q, egYLevel_q, egZLevel_q;
    // Buffer state
    reg  [AW-1:0] wrPtr_q;
    reg  [AW-1:0] rdPtr_q;
    reg  [AW:0]   count_q;
    reg  [AW:0]   count_d;
    reg           watermark_q, overrun_q, stopped_q;
    reg  [SW-1:0] outX_q, outY_q, outZ_q;
    reg  [6:0]    burstAddr_q;
    reg  [1:0]    intPin_q;
    reg  [7:0]    rdByte;
    // Decoded controls and buffer handshakes
    wire [3*SW-1:0] memRdData;
    wire [2:0]      mode;
    wire [4:0]      wmLevel;
    wire [AW:0]     wmWide;
    wire            stopAtWm;
    wire [1:0]      beh;
    wire            operate;
    wire [AW:0]     depthLimit;
    wire            full, empty, accept, rdFire;
    wire            wrNormal, overwrite, wrEn;
    wire [6:0]      effAddr;
    wire [4:0]      fieldCount;
    wire [2:0]      events;
    wire [5:0]      pinEnables;
    wire [1:0]      pinReq;

    assign mode     = bufCtrl_q[`BC_MODE_MSB:`BC_MODE_LSB];
    assign wmLevel  = bufCtrl_q[`BC_WM_MSB:`BC_WM_LSB];
    assign wmWide   = {1'b0, wmLevel};
    assign stopAtWm = ctrlThree_q[`CT3_STOP_AT_WM];

    // Mode decode; disabled buffer behaves as bypass
    assign beh = behaviour(ctrlThree_q[`CT3_BUF_ENABLE],
                           mode, eventGenActive);
    assign operate = (beh != BEH_BYPASS);
    // Usable depth, optionally cut to watermark level minus one, or one slot for levels below two
    assign depthLimit = !stopAtWm ? FULL_DEPTH :
                        (wmWide > ONE_SLOT) ? wmWide - ONE_SLOT :
                        ONE_SLOT;
    assign full  = (count_q >= depthLimit);
    assign empty = (count_q == ZERO_COUNT);
    // Sample intake; a stopped fill refuses further samples
    assign accept = operate && sampleValid &&
                    !((beh == BEH_FILL) && stopped_q);

    // Read address: fresh address or the running burst address
    assign effAddr = regRdNext ? burstAddr_q : regAddr;
    // A triplet pops only when data is stored
    assign rdFire = regRd && operate && !empty &&
                    (effAddr == `ADDR_X_LOW);

    // Normal store, or overwrite of the oldest slot when full
    assign wrNormal  = accept && (!full || rdFire);
    assign overwrite = accept && full && !rdFire;
    assign wrEn      = wrNormal || overwrite;

    // Stored count shown in five bits, saturating when all slots hold data
    assign fieldCount = (count_q > MAX_FIELD) ? MAX_FIELD[4:0] :
                        count_q[4:0];

    sample_slot_mem #(.WIDTH(3*SW), .DEPTH(SLOTS), .AW(AW)) slotMem (
        .clk    (ref_clk),
        .wrEn   (wrEn),
        .wrAddr (wrPtr_q),
        .wrData ({sampleZ, sampleY, sampleX}),
        .rdAddr (rdPtr_q),
        .rdData (memRdData)
    );

    // Software register writes
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrlThree_q <= `RST_CONTROL;
            ctrlSix_q   <= `RST_CONTROL;
            ctrlSeven_q <= `RST_CONTROL;
            bufCtrl_q   <= `RST_BUF_CONTROL;
            egConfig_q  <= `RST_EG;
            egXLevel_q  <= `RST_EG;
            egYLevel_q  <= `RST_EG;
            egZLevel_q  <= `RST_EG;
        end else if (regWr) begin
            if (regAddr == `ADDR_CONTROL_THREE) begin
                ctrlThree_q <= regWrData;
            end else if (regAddr == `ADDR_CONTROL_SIX) begin
                ctrlSix_q <= regWrData;
            end else if (regAddr == `ADDR_CONTROL_SEVEN) begin
                ctrlSeven_q <= regWrData;
            end else if (regAddr == `ADDR_BUF_CONTROL) begin
                bufCtrl_q <= regWrData;
            end else if (regAddr == `ADDR_EG_CONFIG) begin
                egConfig_q <= regWrData;
            end else if (regAddr == `ADDR_EG_X_LEVEL) begin
                egXLevel_q <= regWrData;
            end else if (regAddr == `ADDR_EG_Y_LEVEL) begin
                egYLevel_q <= regWrData;
            end else if (regAddr == `ADDR_EG_Z_LEVEL) begin
                egZLevel_q <= regWrData;
            end
        end
    end

    // Next stored count: plus one per store, minus one per pop
    always @* begin
        count_d = count_q;
        if (wrNormal && !rdFire) begin
            count_d = count_q + ONE_SLOT;
        end else if (rdFire && !wrNormal) begin
            count_d = count_q - ONE_SLOT;
        end
    end

    // Pointers, count and stop state; bypass holds everything reset
    always @(posedge ref_clk) begin
        if (rst || !operate) begin
            wrPtr_q   <= PTR_ZERO;
            rdPtr_q   <= PTR_ZERO;
            count_q   <= ZERO_COUNT;
            stopped_q <= 1'b0;
        end else begin
            if (wrEn) begin
                wrPtr_q <= wrPtr_q + PTR_ONE;
            end
            if (rdFire || overwrite) begin
                rdPtr_q <= rdPtr_q + PTR_ONE;
            end
            count_q <= count_d;
            if (overwrite && (beh == BEH_FILL)) begin
                stopped_q <= 1'b1;
            end
        end
    end

    // Watermark flag; a set in the same cycle as a clear wins
    always @(posedge ref_clk) begin
        if (rst || !operate) begin
            watermark_q <= 1'b0;
        end else if (accept && (count_d >= wmWide)) begin
            watermark_q <= 1'b1;
        end else if (rdFire && (count_d <= wmWide)) begin
            watermark_q <= 1'b0;
        end
    end

    // Overrun flag; cleared by a pop, an overwrite in the same cycle wins
    always @(posedge ref_clk) begin
        if (rst || !operate) begin
            overrun_q <= 1'b0;
        end else if (overwrite) begin
            overrun_q <= 1'b1;
        end else if (rdFire) begin
            overrun_q <= 1'b0;
        end
    end

    // Output registers: live samples in bypass, popped triplet otherwise
    always @(posedge ref_clk) begin
        if (rst) begin
            outX_q <= `RST_SAMPLE;
            outY_q <= `RST_SAMPLE;
            outZ_q <= `RST_SAMPLE;
        end else if (rdFire) begin
            outX_q <= memRdData[SW-1:0];
            outY_q <= memRdData[2*SW-1:SW];
            outZ_q <= memRdData[3*SW-1:2*SW];
        end else if (!operate && sampleValid) begin
            outX_q <= sampleX;
            outY_q <= sampleY;
            outZ_q <= sampleZ;
        end
    end

    // Read multiplexer over the register map
    always @* begin
        rdByte = `UNMAPPED_READ;
        if (effAddr == `ADDR_CONTROL_THREE) begin
            rdByte = ctrlThree_q;
        end else if (effAddr == `ADDR_CONTROL_SIX) begin
            rdByte = ctrlSix_q;
        end else if (effAddr == `ADDR_CONTROL_SEVEN) begin
            rdByte = ctrlSeven_q;
        end else if (effAddr == `ADDR_X_LOW) begin
            // A pop answers with the fresh triplet, otherwise the held one
            rdByte = rdFire ? memRdData[7:0] : outX_q[7:0];
        end else if (effAddr == `ADDR_X_HIGH) begin
            rdByte = outX_q[15:8];
        end else if (effAddr == `ADDR_Y_LOW) begin
            rdByte = outY_q[7:0];
        end else if (effAddr == `ADDR_Y_HIGH) begin
            rdByte = outY_q[15:8];
        end else if (effAddr == `ADDR_Z_LOW) begin
            rdByte = outZ_q[7:0];
        end else if (effAddr == `ADDR_Z_HIGH) begin
            rdByte = outZ_q[15:8];
        end else if (effAddr == `ADDR_BUF_CONTROL) begin
            rdByte = bufCtrl_q;
        end else if (effAddr == `ADDR_BUF_STATE) begin
            rdByte = {watermark_q, overrun_q, empty, fieldCount};
        end else if (effAddr == `ADDR_EG_CONFIG) begin
            rdByte = egConfig_q;
        end else if (effAddr == `ADDR_EG_SOURCE) begin
            rdByte = {1'b0, eventGenActive, 6'h00};
        end else if (effAddr == `ADDR_EG_X_LEVEL) begin
            rdByte = egXLevel_q;
        end else if (effAddr == `ADDR_EG_Y_LEVEL) begin
            rdByte = egYLevel_q;
        end else if (effAddr == `ADDR_EG_Z_LEVEL) begin
            rdByte = egZLevel_q;
        end
    end

    // Read data and burst address registers
    always @(posedge ref_clk) begin
        if (rst) begin
            regRdData   <= `UNMAPPED_READ;
            burstAddr_q <= `ADDR_X_LOW;
        end else if (regRd) begin
            regRdData   <= rdByte;
            burstAddr_q <= nextAddr(effAddr);
        end
    end

    // Event routing: bit 2 overrun, bit 1 watermark, bit 0 empty
    assign events     = {overrun_q, watermark_q, empty && operate};
    assign pinEnables = {ctrlSix_q[`CT6_P2_OVERRUN],
                         ctrlSix_q[`CT6_P2_WATERMARK],
                         ctrlSix_q[`CT6_P2_EMPTY],
                         ctrlThree_q[`CT3_P1_OVERRUN],
                         ctrlThree_q[`CT3_P1_WATERMARK],
                         ctrlThree_q[`CT3_P1_EMPTY]};
    // Per-pin request: any enabled event raises that pin
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : pinGen
            assign pinReq[p] = |(pinEnables[3*p+2:3*p] & events);
        end
    endgenerate
    // Registered interrupt pins, one process drives both bits
    always @(posedge ref_clk) begin
        if (rst) begin
            intPin_q <= 2'b00;
        end else begin
            intPin_q <= pinReq;
        end
    end
    assign interruptPinOne = intPin_q[0];
    assign interruptPinTwo = intPin_q[1];

    // Configuration handed to the event generator
    assign eventGenConfig       = egConfig_q;
    assign eventGenXLevel       = egXLevel_q;
    assign eventGenYLevel       = egYLevel_q;
    assign eventGenZLevel       = egZLevel_q;
    assign eventGenLatchRequest = ctrlSeven_q[`CT7_LATCH_REQ];

endmodule // accel_sample_fifo

`default_nettype wire

// ---- shared/accel_fifo_consts.vh ----
// Register map, field positions, mode codes and reset values of the sample buffer
`ifndef ACCEL_FIFO_CONSTS_VH
`define ACCEL_FIFO_CONSTS_VH

// Register offsets
`define ADDR_CONTROL_THREE     7'h22
`define ADDR_CONTROL_SIX       7'h25
`define ADDR_CONTROL_SEVEN     7'h26
`define ADDR_X_LOW             7'h28
`define ADDR_X_HIGH            7'h29
`define ADDR_Y_LOW             7'h2A
`define ADDR_Y_HIGH            7'h2B
`define ADDR_Z_LOW             7'h2C
`define ADDR_Z_HIGH            7'h2D
`define ADDR_BUF_CONTROL       7'h2E
`define ADDR_BUF_STATE         7'h2F
`define ADDR_EG_CONFIG         7'h30
`define ADDR_EG_SOURCE         7'h31
`define ADDR_EG_X_LEVEL        7'h32
`define ADDR_EG_Y_LEVEL        7'h33
`define ADDR_EG_Z_LEVEL        7'h34

// Field positions in control_three
`define CT3_BUF_ENABLE         7
`define CT3_STOP_AT_WM         6
`define CT3_P1_OVERRUN         2
`define CT3_P1_WATERMARK       1
`define CT3_P1_EMPTY           0
// Field positions in control_six
`define CT6_P2_OVERRUN         2
`define CT6_P2_WATERMARK       1
`define CT6_P2_EMPTY           0
// Field positions in control_seven
`define CT7_LATCH_REQ          2
// Field positions in buffer_control
`define BC_MODE_MSB            7
`define BC_MODE_LSB            5
`define BC_WM_MSB              4
`define BC_WM_LSB              0
// Field positions in buffer_state and event_gen_one_source
`define BS_WATERMARK           7
`define BS_OVERRUN             6
`define BS_EMPTY               5
`define ES_ACTIVE              6

// Buffer mode codes
`define MODE_BYPASS            3'h0
`define MODE_FILL              3'h1
`define MODE_STREAM            3'h2
`define MODE_STREAM_TO_FILL    3'h3
`define MODE_BYPASS_TO_STREAM  3'h4
`define MODE_BYPASS_TO_FILL    3'h7

// Reset values
`define RST_CONTROL            8'h00
`define RST_BUF_CONTROL        8'h00
`define RST_EG                 8'h00
`define RST_SAMPLE             16'h0000
`define UNMAPPED_READ          8'h00

`endif

// ---- hdl/sample_slot_mem.v ----
// Slot memory holding buffered X, Y, Z triplets with registered read data
`timescale 1ns/1ps
`default_nettype none

module sample_slot_mem #(
    parameter WIDTH = 48,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);

    reg [WIDTH-1:0] store [0:DEPTH-1];

    // Write port and registered read port; read sees old data on a collision
    always @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdData <= store[rdAddr];
    end

endmodule // sample_slot_mem

`default_nettype wire

// ---- tb/accel_sample_fifo_monitor.sv ----
// Checker of the register-side behaviour of the sample buffer
`timescale 1ns/1ps
`default_nettype none

module accel_sample_fifo_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [6:0] regAddr,
    input wire logic       regWr,
    input wire logic [7:0] regWrData,
    input wire logic       regRd,
    input wire logic       regRdNext,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] eventGenConfig,
    input wire logic [7:0] eventGenXLevel,
    input wire logic       eventGenLatchRequest,
    input wire logic       interruptPinOne,
    input wire logic       interruptPinTwo
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Plain read by address, not following the burst pointer
    wire rdA = regRd && !regRdNext;

    // Outputs come out of reset quiet
    property p_reset_out;
        $fell(rst) |-> regRdData == 8'h00 && !interruptPinOne
            && !interruptPinTwo;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not cleared by reset");

    // Latch request follows bit 2 of control_seven
    property p_latch;
        regWr && regAddr == 7'h26
            |=> eventGenLatchRequest == $past(regWrData[2]);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch request not taken");

    // Latch request moves only on its own write
    property p_latch_hold;
        !(regWr && regAddr == 7'h26) |=> $stable(eventGenLatchRequest);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch request moved without write");

    property p_cfg;
        regWr && regAddr == 7'h30 |=> eventGenConfig == $past(regWrData);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("event config not written");

    property p_xlev;
        regWr && regAddr == 7'h32 |=> eventGenXLevel == $past(regWrData);
    endproperty
    a_xlev: assert property (p_xlev)
        else $error("event x level not written");

    property p_cfg_rd;
        rdA && regAddr == 7'h30 |=> regRdData == $past(eventGenConfig);
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("event config read back wrong");

    // Read data holds between reads
    property p_hold;
        !regRd |=> $stable(regRdData);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed without read");

    property p_unmap;
        rdA && regAddr > 7'h34 |=> regRdData == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
endmodule // accel_sample_fifo_monitor

bind accel_sample_fifo accel_sample_fifo_monitor mon (
    .ref_clk, .rst, .regAddr, .regWr, .regWrData, .regRd, .regRdNext,
    .regRdData, .eventGenConfig, .eventGenXLevel, .eventGenLatchRequest,
    .interruptPinOne, .interruptPinTwo
);

`default_nettype wire

// ---- tb/host_reg_model.sv ----
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none

module host_reg_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] regRdData,
    output var  logic [6:0] regAddr,
    output var  logic       regWr,
    output var  logic [7:0] regWrData,
    output var  logic       regRd,
    output var  logic       regRdNext
);
    // Idle port at time zero
    initial begin
        regAddr = 7'h00;
        regWr = 1'b0;
        regWrData = 8'h00;
        regRd = 1'b0;
        regRdNext = 1'b0;
    end

    // One-cycle write; released lines show the inverse value
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge ref_clk);
        regWr = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    // One-cycle read, data taken once it has landed
    task rd(input logic [6:0] a, input logic nx, output logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regRdNext = nx;
        regRd = 1'b1;
        @(negedge ref_clk);
        regRd = 1'b0;
        regAddr = ~a;
        regRdNext = ~nx;
        @(negedge ref_clk);
        d = regRdData;
    endtask
endmodule // host_reg_model

`default_nettype wire

// ---- tb/accel_sample_fifo_tb_top.sv ----
// Self-checking bench of the sample buffer
`timescale 1ns/1ps
`default_nettype none
`include "accel_fifo_consts.vh"

module accel_sample_fifo_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        sampleValid = 1'b0;
    logic [15:0] sampleX = 16'h0000;
    logic [15:0] sampleY = 16'h0000;
    logic [15:0] sampleZ = 16'h0000;
    logic        eventGenActive = 1'b0;
    wire  [6:0]  regAddr;
    wire         regWr;
    wire  [7:0]  regWrData;
    wire         regRd;
    wire         regRdNext;
    wire  [7:0]  regRdData;
    wire  [7:0]  eventGenConfig;
    wire  [7:0]  eventGenXLevel;
    wire  [7:0]  eventGenYLevel;
    wire  [7:0]  eventGenZLevel;
    wire         eventGenLatchRequest;
    wire         pinOne;
    wire         pinTwo;
    int          num_errors = 0;
    int          check_count = 0;
    logic [47:0] q[$];
    logic [5:0]  tbl [12] = '{6'h20, 6'h25, 6'h29, 6'h2D, 6'h2F, 6'h30,
                              6'h33, 6'h3C, 6'h3F, 6'h04, 6'h34, 6'h3A};
    logic [6:0]  rstAddr [5] = '{7'h22, 7'h25, 7'h26, 7'h2E, 7'h30};

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    accel_sample_fifo DUT (
        .ref_clk, .rst, .regAddr, .regWr, .regWrData, .regRd, .regRdNext,
        .regRdData, .sampleValid, .sampleX, .sampleY, .sampleZ,
        .eventGenActive, .eventGenConfig, .eventGenXLevel,
        .eventGenYLevel, .eventGenZLevel, .eventGenLatchRequest,
        .interruptPinOne(pinOne), .interruptPinTwo(pinTwo)
    );

    host_reg_model host (
        .ref_clk, .regRdData, .regAddr, .regWr, .regWrData, .regRd,
        .regRdNext
    );

    function automatic logic [7:0] exp_state(int c, bit w, bit o);
        return {w, o, c == 0, c > 31 ? 5'd31 : 5'(c)};
    endfunction

    task chk(string n, logic [7:0] s, logic [7:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task state(input logic [7:0] e);
        logic [7:0] d;
        host.rd(`ADDR_BUF_STATE, 1'b0, d);
        chk("state", d, e);
    endtask

    // One random triplet pulse, then room for the memory latency
    task push(input bit keep);
        @(negedge ref_clk);
        sampleX = 16'($urandom());
        sampleY = 16'($urandom());
        sampleZ = 16'($urandom());
        sampleValid = 1'b1;
        @(negedge ref_clk);
        sampleValid = 1'b0;
        if (keep) q.push_back({sampleZ, sampleY, sampleX});
        @(negedge ref_clk);
    endtask

    // Triplets read as one continuous burst through the wrap
    task drain(input int n);
        logic [47:0] e;
        logic [7:0]  d;
        for (int i = 0; i < n; i++) begin
            e = q.pop_front();
            for (int b = 0; b < 6; b++) begin
                host.rd(`ADDR_X_LOW, (i + b) != 0, d);
                chk("out", d, e[8*b +: 8]);
            end
        end
    endtask

    task finish_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #500000;
        num_errors++;
        finish_test();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] r;
        logic [47:0] lt;
        void'($urandom(32'h0A59F20C));
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        // Reset values and event-generator registers
        foreach (rstAddr[i]) begin
            host.rd(rstAddr[i], 1'b0, d);
            chk("reset", d, 8'h00);
        end
        state(8'h20);
        host.rd(7'h40, 1'b0, d);
        chk("unmapped", d, 8'h00);
        r = 8'($urandom());
        host.wr(`ADDR_EG_CONFIG, r);
        host.wr(`ADDR_EG_X_LEVEL, ~r);
        host.wr(`ADDR_EG_Y_LEVEL, r ^ 8'h5A);
        host.wr(`ADDR_EG_Z_LEVEL, r ^ 8'hA5);
        host.rd(`ADDR_EG_CONFIG, 1'b0, d);
        chk("egcfg", d, r);
        chk("egx", eventGenXLevel, ~r);
        chk("egy", eventGenYLevel, r ^ 8'h5A);
        chk("egz", eventGenZLevel, r ^ 8'hA5);
        host.wr(`ADDR_CONTROL_SEVEN, 8'h04);
        chk("latch", {7'h00, eventGenLatchRequest}, 8'h01);
        // Every mode code; the triggered ones with the active flag low and high, plus a disabled buffer
        foreach (tbl[i]) begin
            eventGenActive = tbl[i][1];
            host.wr(`ADDR_BUF_CONTROL, 8'h00);
            host.wr(`ADDR_CONTROL_THREE, {tbl[i][5], 7'h05});
            host.wr(`ADDR_BUF_CONTROL, {tbl[i][4:2], 5'd4});
            push(1'b0);
            state(exp_state(tbl[i][0], 0, 0));
        end
        eventGenActive = 1'b0;
        // Fill mode up to full, then one overwrite
        host.wr(`ADDR_BUF_CONTROL, 8'h00);
        host.wr(`ADDR_CONTROL_THREE, 8'h85);
        host.wr(`ADDR_CONTROL_SIX, 8'h02);
        host.wr(`ADDR_BUF_CONTROL, 8'h24);
        state(8'h20);
        chk("pin1 empty", {7'h00, pinOne}, 8'h01);
        for (int i = 1; i <= 32; i++) begin
            push(1'b1);
            state(exp_state(i, i >= 4, 0));
        end
        chk("pin1", {7'h00, pinOne}, 8'h00);
        chk("pin2", {7'h00, pinTwo}, 8'h01);
        push(1'b0);
        state(exp_state(32, 1, 1));
        chk("pin1 ovr", {7'h00, pinOne}, 8'h01);
        host.wr(`ADDR_BUF_CONTROL, 8'h00);
        state(8'h20);
        // Refill six, host reads watermark plus one triplets, then the last
        q.delete();
        host.wr(`ADDR_BUF_CONTROL, 8'h24);
        repeat (6) push(1'b1);
        drain(5);
        state(exp_state(1, 0, 0));
        lt = q[0];
        drain(1);
        state(8'h20);
        host.rd(`ADDR_X_LOW, 1'b0, d);
        chk("empty read", d, lt[7:0]);
        host.rd(`ADDR_BUF_STATE, 1'b0, r);
        chk("empty state", r, 8'h20);
        // Stream mode drops the oldest triplets
        q.delete();
        host.wr(`ADDR_BUF_CONTROL, 8'h00);
        host.wr(`ADDR_BUF_CONTROL, 8'h48);
        repeat (34) begin
            push(1'b1);
            if (q.size() > 32) void'(q.pop_front());
        end
        state(exp_state(32, 1, 1));
        drain(32);
        state(8'h20);
        // Stop at watermark gives depth of level minus one
        host.wr(`ADDR_BUF_CONTROL, 8'h00);
        host.wr(`ADDR_CONTROL_THREE, 8'hC5);
        host.wr(`ADDR_BUF_CONTROL, 8'h24);
        repeat (3) push(1'b0);
        state(8'h03);
        push(1'b0);
        state(8'h43);
        finish_test();
    end
endmodule // accel_sample_fifo_tb_top

`default_nettype wire
